// ### logic/vectored_interrupt_controller.sv
// Vectored interrupt controller: flags, gating, priority and dispatch.
`timescale 1ns/1ps
`include "irq_map.svh"
module vectored_interrupt_controller
  import irq_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         clk_en,
  input  wire logic         phase_two_clock,
  input  wire pin_in_type   pins,
  input  wire event_in_type events,
  input  wire pc_type       next_pc,
  input  wire logic         return_from_irq_instr,
  input  wire logic         call_instr,
  input  wire logic         sw_global_set,
  input  wire logic         sw_global_clear,
  input  wire src_vec_type  sw_enable_wr,
  input  wire src_vec_type  sw_enable_data,
  input  wire src_vec_type  sw_flag_clear,
  input  wire src_vec_type  sw_flag_set,
  output logic              global_irq_enable,
  output src_vec_type       irq_enables,
  output src_vec_type       irq_flags,
  output logic              pc_load,
  output pc_type            pc_load_value,
  output logic              irq_taken,
  output logic              stack_full,
  output logic [`SP_WIDTH-1:0] stack_depth
);
  logic ext_fall, pc0_fall, pc5_fall, pc7_rise, per_fall, ser_rise;

  pin_sync u_sync_ext (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .pin_in(pins.pin_falling),
                       .fall_pulse(ext_fall), .rise_pulse());
  pin_sync u_sync_pc0 (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .pin_in(pins.port_c_bit0),
                       .fall_pulse(pc0_fall), .rise_pulse());
  pin_sync u_sync_pc5 (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .pin_in(pins.port_c_bit5),
                       .fall_pulse(pc5_fall), .rise_pulse());
  pin_sync u_sync_pc7 (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .pin_in(pins.port_c_bit7),
                       .fall_pulse(), .rise_pulse(pc7_rise));
  pin_sync u_sync_per (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .pin_in(pins.ext_periph),
                       .fall_pulse(per_fall), .rise_pulse());
  pin_sync u_sync_ser (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .pin_in(pins.serial_event),
                       .fall_pulse(), .rise_pulse(ser_rise));

  // Picks the highest-priority pending source; bit 0 is the highest.
  function automatic src_vec_type pick_one(input src_vec_type req);
    src_vec_type one;
    one = '0;
    for (int i = `NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        one = '0;
        one[i] = 1'b1;
      end
    end
    return one;
  endfunction : pick_one

  function automatic pc_type vector_of(input src_vec_type one);
    pc_type v;
    v = '0;
    case (1'b1)
      one[`SRC_PIN]:        v = `VEC_PIN;
      one[`SRC_TIMER_ZERO]: v = `VEC_TIMER_ZERO;
      one[`SRC_TIMER_ONE]:  v = `VEC_TIMER_ONE;
      one[`SRC_TONE_RX]:    v = `VEC_TONE_RX;
      one[`SRC_CLOCK_TICK]: v = `VEC_CLOCK_TICK;
      one[`SRC_COMBINED]:   v = `VEC_COMBINED;
      default:              v = '0;
    endcase
    return v;
  endfunction : vector_of

  src_vec_type    flags_q, flags_d, enables_q, enables_d, events_now, grant;
  logic           global_q, global_d, p2_q, p2_d, p2_rise, accept;
  logic           pc_load_q, pc_load_d, taken_q, taken_d;
  pc_type         pc_val_q, pc_val_d, stack_top;
  disp_state_type state_q, state_d;
  logic           push, pop;

  assign p2_rise = phase_two_clock & ~p2_q;

  always_comb begin
    events_now                  = '0;
    events_now[`SRC_PIN]        = ext_fall;
    events_now[`SRC_TIMER_ZERO] = events.timer_zero_ovf;
    events_now[`SRC_TIMER_ONE]  = events.timer_one_ovf;
    events_now[`SRC_TONE_RX]    = events.tone_rx_valid;
    events_now[`SRC_CLOCK_TICK] = events.clock_tick;
    events_now[`SRC_COMBINED]   = pc0_fall | pc5_fall | pc7_rise | ser_rise |
                                  per_fall | events.timer_two_ovf;
  end

  always_comb begin
    grant  = pick_one(flags_q & enables_q);
    accept = (state_q == ST_RUN) && p2_rise && global_q && !stack_full &&
             (grant != '0);
    push   = accept;
    // A return is only honoured where the address it pops is also loaded.
    pop    = return_from_irq_instr && !accept && (state_q == ST_RUN);
  end

  always_comb begin
    enables_d = enables_q;
    for (int i = 0; i < `NUM_SRC; i++) begin
      if (sw_enable_wr[i]) begin
        enables_d[i] = sw_enable_data[i];
      end
    end
    // Hardware set wins over any clear in the same cycle.
    flags_d = (flags_q & ~sw_flag_clear & ~(accept ? grant : '0)) |
              sw_flag_set | events_now;
    global_d = global_q;
    if (sw_global_clear) begin
      global_d = 1'b0;
    end
    if (sw_global_set) begin
      global_d = 1'b1;
    end
    if (accept) begin
      global_d = 1'b0;
    end
    p2_d      = phase_two_clock;
    pc_load_d = 1'b0;
    taken_d   = 1'b0;
    pc_val_d  = pc_val_q;
    state_d   = state_q;
    case (state_q)
      ST_RUN: begin
        if (accept) begin
          pc_load_d = 1'b1;
          taken_d   = 1'b1;
          pc_val_d  = vector_of(grant);
          state_d   = ST_ENTER;
        end else if (return_from_irq_instr) begin
          pc_load_d = 1'b1;
          pc_val_d  = stack_top;
        end
      end
      ST_ENTER: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flags_q   <= `FLAGS_RESET;
      enables_q <= '0;
      global_q  <= `GLOBAL_RESET;
      p2_q      <= 1'b0;
      pc_load_q <= 1'b0;
      taken_q   <= 1'b0;
      pc_val_q  <= '0;
      state_q   <= ST_RUN;
    end else if (clk_en) begin
      flags_q   <= flags_d;
      enables_q <= enables_d;
      global_q  <= global_d;
      p2_q      <= p2_d;
      pc_load_q <= pc_load_d;
      taken_q   <= taken_d;
      pc_val_q  <= pc_val_d;
      state_q   <= state_d;
    end
  end

  // The call instruction also consumes a level, so it counts toward full.
  pc_stack u_stack (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .push(push | (call_instr & !accept)),
                    .pop(pop), .push_data(next_pc), .top_data(stack_top), .full(stack_full),
                    .depth(stack_depth));

  assign global_irq_enable = global_q;
  assign irq_enables       = enables_q;
  assign irq_flags         = flags_q;
  assign pc_load           = pc_load_q;
  assign pc_load_value     = pc_val_q;
  assign irq_taken         = taken_q;
endmodule : vectored_interrupt_controller

// ### logic/irq_map.svh
// Constants of the vectored interrupt controller.
// Summary of operation
// - Source events set their matching request flags.
// - Accept pushes next PC, loads vector address.
// - Return instruction pops saved PC back.
// - Servicing clears global enable, preventing nesting.
// - Flags still latch while global enable clear.
// - Full stack blocks acknowledging any interrupt.
// - Per-source enables and global enable gate requests.
// - Requests serviced at next phase-two pulse.
// - Fixed priority: pin, timers, tone, clock, combined.
// - Pin falling edge sets flag, vector 04H.
// - Servicing clears the serviced source's flag.
// - Timer overflows set flags, vectors 08H, 0CH.
// - Valid tone character sets flag, vector 10H.
// - Clock tick sets flag, vector 14H.
// - Combined events set flag, vector 18H.
// - Flags hold until serviced or cleared.
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH
`define PC_WIDTH        14
`define STACK_DEPTH     8
`define SP_WIDTH        4
`define NUM_SRC         6
`define SRC_PIN         0
`define SRC_TIMER_ZERO  1
`define SRC_TIMER_ONE   2
`define SRC_TONE_RX     3
`define SRC_CLOCK_TICK  4
`define SRC_COMBINED    5
`define VEC_PIN         14'h0004
`define VEC_TIMER_ZERO  14'h0008
`define VEC_TIMER_ONE   14'h000C
`define VEC_TONE_RX     14'h0010
`define VEC_CLOCK_TICK  14'h0014
`define VEC_COMBINED    14'h0018
`define FLAGS_RESET     6'h00
`define GLOBAL_RESET    1'b0
`endif

// ### logic/irq_pkg.sv
// Types shared by the interrupt controller files.
package irq_pkg;
  typedef logic [5:0]  src_vec_type;
  typedef logic [13:0] pc_type;
  typedef struct packed {
    logic pin_falling;
    logic port_c_bit0;
    logic port_c_bit5;
    logic port_c_bit7;
    logic serial_event;
    logic ext_periph;
  } pin_in_type;
  typedef struct packed {
    logic timer_zero_ovf;
    logic timer_one_ovf;
    logic tone_rx_valid;
    logic clock_tick;
    logic timer_two_ovf;
  } event_in_type;
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_ENTER = 2'b01
  } disp_state_type;
endpackage : irq_pkg

// ### logic/pin_sync.sv
// Three-stage synchroniser with agreement filter and edge outputs.
`timescale 1ns/1ps
module pin_sync (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic clk_en,
  input  wire logic pin_in,
  output logic      fall_pulse,
  output logic      rise_pulse
);
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic       level_q;
  logic       level_d;

  always_comb begin
    sync_d  = {sync_q[1:0], pin_in};
    level_d = level_q;
    if (sync_q[1] == sync_q[2]) begin
      level_d = sync_q[2];
    end
  end

  // Level resets high so an idle-high pin gives no false edge.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync_q  <= 3'h7;
      level_q <= 1'b1;
    end else if (clk_en) begin
      sync_q  <= sync_d;
      level_q <= level_d;
    end
  end

  assign fall_pulse = clk_en & level_q & ~level_d;
  assign rise_pulse = clk_en & ~level_q & level_d;
endmodule : pin_sync

// ### logic/pc_stack.sv
// Program counter return stack with push, pop and full indication.
`timescale 1ns/1ps
`include "irq_map.svh"
module pc_stack
  import irq_pkg::*;
(
  input  wire logic   clk_sys,
  input  wire logic   resetn,
  input  wire logic   clk_en,
  input  wire logic   push,
  input  wire logic   pop,
  input  wire pc_type push_data,
  output pc_type      top_data,
  output logic        full,
  output logic [`SP_WIDTH-1:0] depth
);
  pc_type                mem_q [`STACK_DEPTH];
  logic [`SP_WIDTH-1:0]  sp_q;
  logic [`SP_WIDTH-1:0]  sp_d;

  assign full     = (sp_q == `SP_WIDTH'(`STACK_DEPTH));
  assign depth    = sp_q;
  assign top_data = (sp_q == '0) ? '0 : mem_q[sp_q[2:0] - 3'h1];

  always_comb begin
    sp_d = sp_q;
    if (push && !full) begin
      sp_d = sp_q + 4'h1;
    end else if (pop && sp_q != '0) begin
      sp_d = sp_q - 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sp_q <= '0;
    end else if (clk_en) begin
      sp_q <= sp_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clk_en && push && !full) begin
      mem_q[sp_q[2:0]] <= push_data;
    end
  end
endmodule : pc_stack

// ### verif/irq_chk.sv
// Assertion checker for the vectored interrupt controller ports.
`timescale 1ns/1ps
`include "irq_map.svh"
module irq_chk
  import irq_pkg::*;
(
  input wire logic          clk_sys,
  input wire logic          resetn,
  input wire logic          phase_two_clock,
  input wire event_in_type  events,
  input wire src_vec_type   sw_flag_clear,
  input wire logic          global_irq_enable,
  input wire src_vec_type   irq_enables,
  input wire src_vec_type   irq_flags,
  input wire logic          pc_load,
  input wire pc_type        pc_load_value,
  input wire logic          irq_taken,
  input wire logic          stack_full,
  input wire logic [`SP_WIDTH-1:0] stack_depth
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_entry;
    pc_load && !global_irq_enable ##1 !irq_taken;
  endsequence
  AST_ENTRY: assert property (irq_taken |-> s_entry) else $error("bad entry pulse");
  AST_P2: assert property (irq_taken |-> $past(phase_two_clock) && !$past(phase_two_clock, 2))
    else $error("entry off the phase edge");
  AST_FULL: assert property (stack_full |=> !irq_taken) else $error("entry while full");
  AST_GATE: assert property (!global_irq_enable |=> !irq_taken) else $error("entry while off");
  AST_VEC: assert property (irq_taken |-> pc_load_value inside {`VEC_PIN, `VEC_TIMER_ZERO,
    `VEC_TIMER_ONE, `VEC_TONE_RX, `VEC_CLOCK_TICK, `VEC_COMBINED}) else $error("bad vector");
  AST_PUSH: assert property (irq_taken |-> stack_depth == $past(stack_depth) + 1'b1)
    else $error("no push on entry");
  AST_PRIO: assert property (irq_taken && pc_load_value != `VEC_PIN |-> !$past(irq_flags[0] && irq_enables[0]))
    else $error("pin source passed over");
  AST_CLR: assert property (irq_taken && pc_load_value == `VEC_TIMER_ZERO && !$past(events.timer_zero_ovf)
    |-> !irq_flags[1]) else $error("served flag kept");
  AST_HOLD: assert property (!irq_taken && $past(sw_flag_clear) == 6'h00
    |-> (irq_flags & $past(irq_flags)) == $past(irq_flags)) else $error("flag lost");
  AST_SET: assert property (events.timer_one_ovf |=> irq_flags[2] || irq_taken)
    else $error("overflow not latched");
endmodule : irq_chk
bind vectored_interrupt_controller irq_chk i_irq_chk (.*);

// ### verif/core_model.sv
// Core-side model: phase-two clock and next instruction address.
`timescale 1ns/1ps
module core_model
  import irq_pkg::*;
(
  input  wire logic   clk_sys,
  input  wire logic   resetn,
  input  wire logic   pc_load,
  input  wire pc_type pc_load_value,
  output logic        phase_two_clock,
  output pc_type      next_pc
);
  logic [1:0] phase_q;
  // The phase-two clock rises once every four cycles.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phase_q <= 2'h0;
      next_pc <= 14'h0100;
    end else begin
      phase_q <= phase_q + 2'h1;
      // Fetch moves to the loaded address; the next instruction follows it.
      if (pc_load) begin
        next_pc <= pc_load_value + 14'h0001;
      end
    end
  end
  assign phase_two_clock = phase_q[1];
endmodule : core_model

// ### verif/tb.sv
// Self-checking testbench for the vectored interrupt controller.
`timescale 1ns/1ps
`include "irq_map.svh"
module tb;
  import irq_pkg::*;
  logic         clk_sys, resetn, clk_en, phase_two_clock, return_from_irq_instr, call_instr;
  logic         sw_global_set, sw_global_clear, global_irq_enable, pc_load, irq_taken, stack_full, hit;
  pin_in_type   pins;
  event_in_type events;
  pc_type       next_pc, pc_load_value;
  src_vec_type  sw_enable_wr, sw_enable_data, sw_flag_clear, sw_flag_set, irq_enables, irq_flags;
  logic [3:0]   stack_depth;
  int           bad_count, checks;
  pc_type       saved [6];
  pc_type       vec [6] = '{`VEC_PIN, `VEC_TIMER_ZERO, `VEC_TIMER_ONE, `VEC_TONE_RX, `VEC_CLOCK_TICK, `VEC_COMBINED};
  vectored_interrupt_controller i_vectored_interrupt_controller (.*);
  core_model i_core_model (.*);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task fire(input int k);
    if (k == 0) begin
      pins.pin_falling = 1'b0;
    end else begin
      events[5-k] = 1'b1;
      tick(1);
      events = 5'h00;
    end
  endtask : fire
  task pulse_global;
    sw_global_set = 1'b1;
    tick(1);
    sw_global_set = 1'b0;
  endtask : pulse_global
  task enables(input src_vec_type wr, input src_vec_type data);
    sw_enable_wr = wr;
    sw_enable_data = data;
    tick(1);
    sw_enable_wr = 6'h00;
  endtask : enables
  task take;
    hit = 1'b0;
    for (int i = 0; i < 40 && hit !== 1'b1; i++) begin
      tick(1);
      hit = irq_taken;
    end
    if (hit !== 1'b1) begin
      chk("entry", 16'h0000, 16'h0001);
      tally_and_finish();
    end
  endtask : take
  task quiet(input int n);
    hit = 1'b0;
    repeat (n) begin
      tick(1);
      hit = hit | irq_taken;
    end
    chk("no entry", hit, 16'h0000);
  endtask : quiet
  task ret;
    tick(1);
    return_from_irq_instr = 1'b1;
    tick(1);
    return_from_irq_instr = 1'b0;
  endtask : ret
  initial begin
    {resetn, return_from_irq_instr, call_instr, sw_global_set, sw_global_clear} = 5'h00;
    {sw_enable_wr, sw_enable_data, sw_flag_clear, sw_flag_set} = 24'h000000;
    clk_en = 1'b1;
    pins = 6'h3F;
    events = 5'h00;
    bad_count = 0;
    checks = 0;
    tick(6);
    resetn = 1'b1;
    chk("flags", irq_flags, 16'h0000);
    chk("global", global_irq_enable, 16'h0000);
    enables(6'h3F, 6'h3F);
    for (int k = 0; k < 6; k++) fire(k);
    tick(4);
    chk("flags", irq_flags, 16'h003F);
    for (int k = 0; k < 6; k++) begin
      pulse_global();
      saved[k] = next_pc;
      take();
      chk("vector", pc_load_value, vec[k]);
      chk("served flag", irq_flags[k], 16'h0000);
      chk("global", global_irq_enable, 16'h0000);
      chk("depth", stack_depth, 16'(k + 1));
    end
    $display("test nesting done");
    for (int k = 5; k >= 0; k--) begin
      ret();
      chk("pop load", pc_load, 16'h0001);
      chk("pop value", pc_load_value, saved[k]);
      chk("depth", stack_depth, 16'(k));
    end
    $display("test return done");
    enables(6'h02, 6'h00);
    chk("enables", irq_enables, 16'h003D);
    fire(1);
    pulse_global();
    quiet(12);
    chk("held flag", irq_flags[1], 16'h0001);
    sw_flag_clear = 6'h02;
    tick(1);
    sw_flag_clear = 6'h00;
    tick(1);
    chk("cleared flag", irq_flags[1], 16'h0000);
    sw_global_clear = 1'b1;
    tick(1);
    sw_global_clear = 1'b0;
    chk("global", global_irq_enable, 16'h0000);
    sw_flag_set = 6'h02;
    tick(1);
    sw_flag_set = 6'h00;
    chk("set flag", irq_flags[1], 16'h0001);
    pulse_global();
    $display("test masking done");
    call_instr = 1'b1;
    tick(8);
    call_instr = 1'b0;
    tick(1);
    chk("full", stack_full, 16'h0001);
    enables(6'h02, 6'h02);
    fire(1);
    quiet(12);
    chk("pending", irq_flags[1], 16'h0001);
    ret();
    chk("depth", stack_depth, 16'h0007);
    take();
    chk("vector", pc_load_value, `VEC_TIMER_ZERO);
    $display("test full stack done");
    tally_and_finish();
  end
endmodule : tb
